// File: bench/bbodr_top_tb_top.sv
module bbodr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        I_CLK;
  logic        I_SYS_RST;
  logic        I_REF_A_CLK;
  logic        I_REF_B_CLK;
  logic        I_REG_WR;
  logic        I_REG_RD;
  logic [3:0]  I_REG_ADDR;
  logic [7:0]  I_REG_WDATA;
  logic        I_BANK_B_GLITCHLESS_HIZ;
  logic        I_DIV_SYNC;
  logic [7:0]  O_REG_RDATA;
  logic [3:0]  O_BANK_B_PAIR_POS;
  logic [3:0]  O_BANK_B_PAIR_NEG;
  logic [3:0]  O_BANK_B_PAIR_OE;
  logic [11:0] O_BANK_B_DRIVER_TYPE;
  logic [3:0]  O_BANK_B_PAIR_OFF;
  logic        O_BANK_B_HCSL_TERM_50;
  logic        O_BANK_A_CLK;
  logic        ref_run;
  logic [1:0]  ref_cnt;
  int          err_count;
  int          n_checks;

  bbodr_top u_bbodr_top (
    .I_CLK                   (I_CLK),
    .I_SYS_RST               (I_SYS_RST),
    .I_REF_A_CLK             (I_REF_A_CLK),
    .I_REF_B_CLK             (I_REF_B_CLK),
    .I_REG_WR                (I_REG_WR),
    .I_REG_RD                (I_REG_RD),
    .I_REG_ADDR              (I_REG_ADDR),
    .I_REG_WDATA             (I_REG_WDATA),
    .I_BANK_B_GLITCHLESS_HIZ (I_BANK_B_GLITCHLESS_HIZ),
    .I_DIV_SYNC              (I_DIV_SYNC),
    .O_REG_RDATA             (O_REG_RDATA),
    .O_BANK_B_PAIR_POS       (O_BANK_B_PAIR_POS),
    .O_BANK_B_PAIR_NEG       (O_BANK_B_PAIR_NEG),
    .O_BANK_B_PAIR_OE        (O_BANK_B_PAIR_OE),
    .O_BANK_B_DRIVER_TYPE    (O_BANK_B_DRIVER_TYPE),
    .O_BANK_B_PAIR_OFF       (O_BANK_B_PAIR_OFF),
    .O_BANK_B_HCSL_TERM_50   (O_BANK_B_HCSL_TERM_50),
    .O_BANK_A_CLK            (O_BANK_A_CLK)
  );

  initial begin
    I_CLK = 1'h0;
    forever #25 I_CLK = ~I_CLK;
  end

  // Reference period of 8 system cycles, slow enough for the 2-flop synchronisers
  always @(posedge I_CLK) begin
    if (ref_run) begin
      ref_cnt <= ref_cnt + 2'h1;
      if (ref_cnt == 2'h3) begin
        I_REF_A_CLK <= ~I_REF_A_CLK;
        I_REF_B_CLK <= ~I_REF_B_CLK;
      end
    end else begin
      ref_cnt     <= 2'h0;
      I_REF_A_CLK <= 1'h0;
      I_REF_B_CLK <= 1'h0;
    end
  end

  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    I_REG_WR    <= 1'h1;
    I_REG_ADDR  <= a;
    I_REG_WDATA <= d;
    @(posedge I_CLK);
    I_REG_WR <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge I_CLK);
    I_REG_RD   <= 1'h1;
    I_REG_ADDR <= a;
    @(posedge I_CLK);
    I_REG_RD <= 1'h0;
    @(posedge I_CLK);
    #1;
    chk("rdata", {4'h0, e}, {4'h0, O_REG_RDATA});
  endtask

  function automatic logic get(input int sel);
    return (sel != 0) ? O_BANK_B_PAIR_POS[0] : O_BANK_A_CLK;
  endfunction

  task automatic wait_lvl(input int sel, input logic lvl, output int n);
    n = 0;
    while (get(sel) !== lvl) begin
      @(posedge I_CLK);
      #1;
      n++;
      if (n > 5000) begin
        err_count++;
        $display("[ERR] clock_wait expected %0d seen timeout", lvl);
        results();
      end
    end
  endtask

  // Skips the first partial period, which may run on an intermediate ratio
  task automatic measure(input int sel, input int e_hi, input int e_per);
    int n;
    int hi;
    int lo;
    // Never read the clock in the time step of the edge that moves it
    #1;
    wait_lvl(sel, 1'h0, n);
    wait_lvl(sel, 1'h1, n);
    wait_lvl(sel, 1'h0, hi);
    wait_lvl(sel, 1'h1, lo);
    chk("high_span", 12'(e_hi), 12'(hi));
    chk("period", 12'(e_per), 12'(hi + lo));
  endtask

  logic [3:0] ra [9] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'hC, 4'hD, 4'hE, 4'hF, 4'hA};
  logic [7:0] re [9] = '{8'h00, 8'h12, 8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};

  initial begin
    int na;
    int nb;
    err_count               = 0;
    n_checks                = 0;
    I_SYS_RST               = 1'h1;
    I_REG_WR                = 1'h0;
    I_REG_RD                = 1'h0;
    I_REG_ADDR              = 4'h0;
    I_REG_WDATA             = 8'h00;
    I_BANK_B_GLITCHLESS_HIZ = 1'h0;
    I_DIV_SYNC              = 1'h0;
    ref_run                 = 1'h0;
    repeat (2) @(posedge I_CLK);
    I_SYS_RST <= 1'h0;
    @(posedge I_CLK);
    #1;
    chk("types", 12'h492, O_BANK_B_DRIVER_TYPE);
    chk("oe", 12'h00F, {8'h00, O_BANK_B_PAIR_OE});
    chk("off_term", 12'h000, {7'h00, O_BANK_B_HCSL_TERM_50, O_BANK_B_PAIR_OFF});
    chk("bank_a", 12'h000, {11'h000, O_BANK_A_CLK});
    for (int i = 0; i < 9; i++)
      rd(ra[i], re[i]);
    wr(4'h6, 8'h10);
    rd(4'h6, 8'h10);
    chk("term", 12'h001, {11'h000, O_BANK_B_HCSL_TERM_50});
    foreach (codes[i]) begin
      wr(4'h8, {5'h02, codes[i]});
      repeat (3) @(posedge I_CLK);
      #1;
      chk("type0", {9'h000, codes[i]}, {9'h000, O_BANK_B_DRIVER_TYPE[2:0]});
      chk("oe0", {11'h000, codes[i] != 3'h0}, {11'h000, O_BANK_B_PAIR_OE[0]});
      rd(4'h8, {5'h02, codes[i]});
    end
    wr(4'h7, 8'h2C);
    #1;
    chk("types32", 12'hB00, {O_BANK_B_DRIVER_TYPE[11:6], 6'h00});
    rd(4'h7, 8'h2C);
    wr(4'h8, 8'h12);
    // Bank parked in high-z before any pair changes state
    @(posedge I_CLK);
    I_BANK_B_GLITCHLESS_HIZ <= 1'h1;
    wr(4'h9, 8'h50);
    repeat (3) @(posedge I_CLK);
    #1;
    chk("oe_hiz", 12'h000, {8'h00, O_BANK_B_PAIR_OE});
    chk("off", 12'h005, {8'h00, O_BANK_B_PAIR_OFF});
    @(posedge I_CLK);
    I_BANK_B_GLITCHLESS_HIZ <= 1'h0;
    repeat (3) @(posedge I_CLK);
    #1;
    chk("oe_part", 12'h00A, {8'h00, O_BANK_B_PAIR_OE});
    @(posedge I_CLK);
    I_BANK_B_GLITCHLESS_HIZ <= 1'h1;
    wr(4'h9, 8'h00);
    I_BANK_B_GLITCHLESS_HIZ <= 1'h0;
    repeat (3) @(posedge I_CLK);
    #1;
    chk("oe_all", 12'h00F, {8'h00, O_BANK_B_PAIR_OE});
    ref_run <= 1'h1;
    wr(4'hC, 8'h01);
    measure(0, 4, 8);
    wr(4'hC, 8'h04);
    measure(0, 16, 32);
    wr(4'hC, 8'h05);
    measure(0, 24, 40);
    wr(4'hC, 8'h03);
    wr(4'hE, 8'h01);
    rd(4'hE, 8'h01);
    measure(0, 1040, 2072);
    wr(4'hE, 8'h00);
    measure(1, 4, 8);
    wr(4'hD, 8'h03);
    rd(4'hD, 8'h03);
    measure(1, 16, 24);
    chk("neg", {8'h00, ~O_BANK_B_PAIR_POS}, {8'h00, O_BANK_B_PAIR_NEG});
    wr(4'hD, 8'h02);
    wr(4'hE, 8'h02);
    measure(1, 1032, 2064);
    wr(4'hC, 8'h04);
    wr(4'hD, 8'h04);
    wr(4'hE, 8'h00);
    @(posedge I_CLK);
    I_DIV_SYNC <= 1'h1;
    repeat (40) @(posedge I_CLK);
    #1;
    chk("halted", 12'h000, {10'h000, O_BANK_A_CLK, O_BANK_B_PAIR_POS[0]});
    @(posedge I_CLK);
    I_DIV_SYNC <= 1'h0;
    wait_lvl(0, 1'h1, na);
    wait_lvl(1, 1'h1, nb);
    chk("release", 12'h001, {11'h000, na <= 16});
    chk("aligned", 12'h001, {11'h000, nb <= 2});
    results();
  end

endmodule

// File: hdl/bbodr_divider.sv
module bbodr_divider (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ref_lvl,
  input  wire logic       i_ref_rise,
  input  wire logic [8:0] i_ratio,
  input  wire logic       i_hold,
  output logic            o_clk_lvl
);

  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic       out_q;
  logic       out_d;
  logic       bypass;

  always_comb begin
    bypass = bbodr_pkg::is_bypass(i_ratio);
    cnt_d  = cnt_q;
    out_d  = out_q;
    if (i_hold) begin
      cnt_d = '0;
      out_d = 1'b0;
    end else if (bypass) begin
      cnt_d = '0;
      out_d = i_ref_lvl;
    end else if (i_ref_rise) begin
      // Wrap also catches a ratio lowered below the running count
      cnt_d = (cnt_q >= i_ratio - 9'h001) ? '0 : cnt_q + 9'h001;
      out_d = cnt_q < bbodr_pkg::high_span(i_ratio);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign o_clk_lvl = out_q;

  property p_div_hold;
    @(posedge i_clk) disable iff (i_rst)
    i_hold |=> (cnt_q == 9'h000) && !out_q;
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider not halted while held");

  property p_div_bypass;
    @(posedge i_clk) disable iff (i_rst)
    (!i_hold && bbodr_pkg::is_bypass(i_ratio)) |=> (out_q == $past(i_ref_lvl));
  endproperty
  a_div_bypass: assert property (p_div_bypass) else $error("bypass does not follow reference");

  property p_div_wrap;
    @(posedge i_clk) disable iff (i_rst)
    (!i_hold && !bypass && i_ref_rise && (cnt_q == i_ratio - 9'h001)) |=> (cnt_q == 9'h000) && !out_q;
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("divider period not equal to ratio");

  property p_div_start_high;
    @(posedge i_clk) disable iff (i_rst)
    (!i_hold && !bypass && i_ref_rise && (cnt_q == 9'h000)) |=> out_q && (cnt_q == 9'h001);
  endproperty
  a_div_start_high: assert property (p_div_start_high) else $error("divided period does not start high");

endmodule

// File: hdl/bbodr_pair.sv
module bbodr_pair (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_clk_lvl,
  input  wire logic [2:0] i_mode,
  input  wire logic       i_off,
  input  wire logic       i_hiz_all,
  output logic            o_pos,
  output logic            o_neg,
  output logic            o_oe
);

  logic en_q;
  logic pos_q;
  logic neg_q;

  // en_q changes only while the bank clock is low, so no runt pulse; a mode write still gates o_oe at once
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      en_q <= 1'b1;
    end else if (!i_clk_lvl) begin
      en_q <= !i_hiz_all && !i_off;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pos_q <= 1'b0;
      neg_q <= 1'b1;
    end else begin
      pos_q <= i_clk_lvl;
      neg_q <= !i_clk_lvl;
    end
  end

  assign o_pos = pos_q;
  assign o_neg = neg_q;
  assign o_oe  = en_q && bbodr_pkg::drives_pair(i_mode);

  property p_pair_hiz;
    @(posedge i_clk) disable iff (i_rst)
    (i_hiz_all && !i_clk_lvl) |=> !o_oe;
  endproperty
  a_pair_hiz: assert property (p_pair_hiz) else $error("pair driven while bank forced high-z");

  property p_pair_off;
    @(posedge i_clk) disable iff (i_rst)
    (i_off && !i_clk_lvl) |=> !o_oe;
  endproperty
  a_pair_off: assert property (p_pair_off) else $error("powered-down pair still driven");

  property p_pair_mode_hiz;
    @(posedge i_clk) disable iff (i_rst)
    (i_mode == bbodr_pkg::MODE_HIZ) |-> !o_oe;
  endproperty
  a_pair_mode_hiz: assert property (p_pair_mode_hiz) else $error("high-z code drives pair");

endmodule

// File: hdl/bbodr_pkg.sv
package bbodr_pkg;

  // Register offsets on the byte register port
  localparam logic [3:0] ADDR_TERM       = 4'h6;
  localparam logic [3:0] ADDR_MODE_32    = 4'h7;
  localparam logic [3:0] ADDR_MODE_10    = 4'h8;
  localparam logic [3:0] ADDR_PAIR_OFF   = 4'h9;
  localparam logic [3:0] ADDR_RATIO_A_LO = 4'hC;
  localparam logic [3:0] ADDR_RATIO_B_LO = 4'hD;
  localparam logic [3:0] ADDR_RATIO_HI   = 4'hE;
  localparam logic [3:0] ADDR_RSVD_F     = 4'hF;

  // Field positions
  localparam int TERM_BIT       = 4;
  localparam int MODE_HI_LSB    = 3;
  localparam int MODE_LO_LSB    = 0;
  localparam int MODE_W         = 3;
  localparam int PAIR_OFF_LSB   = 4;
  localparam int RATIO_HI_A_BIT = 0;
  localparam int RATIO_HI_B_BIT = 1;
  localparam int NUM_PAIRS      = 4;
  localparam int RATIO_W        = 9;

  // Driver-type codes
  localparam logic [2:0] MODE_HIZ    = 3'h0;
  localparam logic [2:0] MODE_LVPECL = 3'h1;
  localparam logic [2:0] MODE_LVDS   = 3'h2;
  localparam logic [2:0] MODE_HCSL   = 3'h4;
  localparam logic [2:0] MODE_CML400 = 3'h5;
  localparam logic [2:0] MODE_CML800 = 3'h6;

  // Reset values
  localparam logic [2:0] MODE_RST     = MODE_LVDS;
  localparam logic       PAIR_OFF_RST = 1'b0;
  localparam logic       TERM_RST     = 1'b0;
  localparam logic [8:0] RATIO_RST    = 9'h000;
  localparam logic [7:0] RDATA_RST    = 8'h00;

  localparam logic [8:0] RATIO_MIN_DIV = 9'h002;

  function automatic logic is_bypass(input logic [8:0] ratio);
    return ratio < RATIO_MIN_DIV;
  endfunction

  // Reserved codes leave the pair undriven
  function automatic logic drives_pair(input logic [2:0] mode);
    return (mode == MODE_LVPECL) || (mode == MODE_LVDS) || (mode == MODE_HCSL) ||
           (mode == MODE_CML400) || (mode == MODE_CML800);
  endfunction

  // Ceiling of half the ratio: the count of high reference periods
  function automatic logic [8:0] high_span(input logic [8:0] ratio);
    logic [9:0] s;
    s = {1'b0, ratio} + 10'h001;
    return s[9:1];
  endfunction

endpackage

// File: hdl/bbodr_top.sv
module bbodr_top (
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_REF_A_CLK,
  input  wire logic        I_REF_B_CLK,
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  input  wire logic [3:0]  I_REG_ADDR,
  input  wire logic [7:0]  I_REG_WDATA,
  input  wire logic        I_BANK_B_GLITCHLESS_HIZ,
  input  wire logic        I_DIV_SYNC,
  output logic      [7:0]  O_REG_RDATA,
  output logic      [3:0]  O_BANK_B_PAIR_POS,
  output logic      [3:0]  O_BANK_B_PAIR_NEG,
  output logic      [3:0]  O_BANK_B_PAIR_OE,
  output logic      [11:0] O_BANK_B_DRIVER_TYPE,
  output logic      [3:0]  O_BANK_B_PAIR_OFF,
  output logic             O_BANK_B_HCSL_TERM_50,
  output logic             O_BANK_A_CLK
);

  logic [3:0][2:0] mode_q;
  logic [3:0]      pair_off_q;
  logic            term_q;
  logic [8:0]      ratio_a_q;
  logic [8:0]      ratio_b_q;
  logic [7:0]      rdata_q;
  logic [7:0]      rdata_d;

  logic            ref_a_meta_q;
  logic            ref_a_sync_q;
  logic            ref_a_prev_q;
  logic            ref_b_meta_q;
  logic            ref_b_sync_q;
  logic            ref_b_prev_q;
  logic            ref_a_rise;
  logic            ref_b_rise;
  logic            bank_a_clk;
  logic            bank_b_clk;

  // Reference pins are asynchronous to I_CLK
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ref_a_meta_q <= 1'b0;
      ref_a_sync_q <= 1'b0;
      ref_a_prev_q <= 1'b0;
    end else begin
      ref_a_meta_q <= I_REF_A_CLK;
      ref_a_sync_q <= ref_a_meta_q;
      ref_a_prev_q <= ref_a_sync_q;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ref_b_meta_q <= 1'b0;
      ref_b_sync_q <= 1'b0;
      ref_b_prev_q <= 1'b0;
    end else begin
      ref_b_meta_q <= I_REF_B_CLK;
      ref_b_sync_q <= ref_b_meta_q;
      ref_b_prev_q <= ref_b_sync_q;
    end
  end

  assign ref_a_rise = ref_a_sync_q && !ref_a_prev_q;
  assign ref_b_rise = ref_b_sync_q && !ref_b_prev_q;

  // Driver-type fields; reserved bits are dropped on write
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      mode_q <= {bbodr_pkg::NUM_PAIRS{bbodr_pkg::MODE_RST}};
    end else if (I_REG_WR) begin
      if (I_REG_ADDR == bbodr_pkg::ADDR_MODE_32) begin
        mode_q[3] <= I_REG_WDATA[bbodr_pkg::MODE_HI_LSB +: bbodr_pkg::MODE_W];
        mode_q[2] <= I_REG_WDATA[bbodr_pkg::MODE_LO_LSB +: bbodr_pkg::MODE_W];
      end else if (I_REG_ADDR == bbodr_pkg::ADDR_MODE_10) begin
        mode_q[1] <= I_REG_WDATA[bbodr_pkg::MODE_HI_LSB +: bbodr_pkg::MODE_W];
        mode_q[0] <= I_REG_WDATA[bbodr_pkg::MODE_LO_LSB +: bbodr_pkg::MODE_W];
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      pair_off_q <= {bbodr_pkg::NUM_PAIRS{bbodr_pkg::PAIR_OFF_RST}};
    end else if (I_REG_WR && (I_REG_ADDR == bbodr_pkg::ADDR_PAIR_OFF)) begin
      pair_off_q <= I_REG_WDATA[bbodr_pkg::PAIR_OFF_LSB +: bbodr_pkg::NUM_PAIRS];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      term_q <= bbodr_pkg::TERM_RST;
    end else if (I_REG_WR && (I_REG_ADDR == bbodr_pkg::ADDR_TERM)) begin
      term_q <= I_REG_WDATA[bbodr_pkg::TERM_BIT];
    end
  end

  // Ratio bytes land independently; a split update may briefly run a mixed ratio
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ratio_a_q <= bbodr_pkg::RATIO_RST;
      ratio_b_q <= bbodr_pkg::RATIO_RST;
    end else if (I_REG_WR) begin
      if (I_REG_ADDR == bbodr_pkg::ADDR_RATIO_A_LO) begin
        ratio_a_q[7:0] <= I_REG_WDATA;
      end else if (I_REG_ADDR == bbodr_pkg::ADDR_RATIO_B_LO) begin
        ratio_b_q[7:0] <= I_REG_WDATA;
      end else if (I_REG_ADDR == bbodr_pkg::ADDR_RATIO_HI) begin
        ratio_a_q[8] <= I_REG_WDATA[bbodr_pkg::RATIO_HI_A_BIT];
        ratio_b_q[8] <= I_REG_WDATA[bbodr_pkg::RATIO_HI_B_BIT];
      end
    end
  end

  // Reserved positions and foreign offsets read as zero
  always_comb begin
    rdata_d = '0;
    if (I_REG_ADDR == bbodr_pkg::ADDR_TERM) begin
      rdata_d[bbodr_pkg::TERM_BIT] = term_q;
    end else if (I_REG_ADDR == bbodr_pkg::ADDR_MODE_32) begin
      rdata_d[bbodr_pkg::MODE_HI_LSB +: bbodr_pkg::MODE_W] = mode_q[3];
      rdata_d[bbodr_pkg::MODE_LO_LSB +: bbodr_pkg::MODE_W] = mode_q[2];
    end else if (I_REG_ADDR == bbodr_pkg::ADDR_MODE_10) begin
      rdata_d[bbodr_pkg::MODE_HI_LSB +: bbodr_pkg::MODE_W] = mode_q[1];
      rdata_d[bbodr_pkg::MODE_LO_LSB +: bbodr_pkg::MODE_W] = mode_q[0];
    end else if (I_REG_ADDR == bbodr_pkg::ADDR_PAIR_OFF) begin
      rdata_d[bbodr_pkg::PAIR_OFF_LSB +: bbodr_pkg::NUM_PAIRS] = pair_off_q;
    end else if (I_REG_ADDR == bbodr_pkg::ADDR_RATIO_A_LO) begin
      rdata_d = ratio_a_q[7:0];
    end else if (I_REG_ADDR == bbodr_pkg::ADDR_RATIO_B_LO) begin
      rdata_d = ratio_b_q[7:0];
    end else if (I_REG_ADDR == bbodr_pkg::ADDR_RATIO_HI) begin
      rdata_d[bbodr_pkg::RATIO_HI_A_BIT] = ratio_a_q[8];
      rdata_d[bbodr_pkg::RATIO_HI_B_BIT] = ratio_b_q[8];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rdata_q <= bbodr_pkg::RDATA_RST;
    end else if (I_REG_RD) begin
      rdata_q <= rdata_d;
    end
  end

  // Both dividers see the same hold, so release lines them up
  bbodr_divider u_div_a (
    .i_clk      (I_CLK),
    .i_rst      (I_SYS_RST),
    .i_ref_lvl  (ref_a_sync_q),
    .i_ref_rise (ref_a_rise),
    .i_ratio    (ratio_a_q),
    .i_hold     (I_DIV_SYNC),
    .o_clk_lvl  (bank_a_clk)
  );

  bbodr_divider u_div_b (
    .i_clk      (I_CLK),
    .i_rst      (I_SYS_RST),
    .i_ref_lvl  (ref_b_sync_q),
    .i_ref_rise (ref_b_rise),
    .i_ratio    (ratio_b_q),
    .i_hold     (I_DIV_SYNC),
    .o_clk_lvl  (bank_b_clk)
  );

  for (genvar p = 0; p < bbodr_pkg::NUM_PAIRS; p++) begin : g_pair
    bbodr_pair u_pair (
      .i_clk     (I_CLK),
      .i_rst     (I_SYS_RST),
      .i_clk_lvl (bank_b_clk),
      .i_mode    (mode_q[p]),
      .i_off     (pair_off_q[p]),
      .i_hiz_all (I_BANK_B_GLITCHLESS_HIZ),
      .o_pos     (O_BANK_B_PAIR_POS[p]),
      .o_neg     (O_BANK_B_PAIR_NEG[p]),
      .o_oe      (O_BANK_B_PAIR_OE[p])
    );
  end

  assign O_REG_RDATA           = rdata_q;
  assign O_BANK_B_DRIVER_TYPE  = mode_q;
  assign O_BANK_B_PAIR_OFF     = pair_off_q;
  assign O_BANK_B_HCSL_TERM_50 = term_q;
  assign O_BANK_A_CLK          = bank_a_clk;

  property p_reset_modes;
    @(posedge I_CLK)
    I_SYS_RST |=> (mode_q == {bbodr_pkg::NUM_PAIRS{bbodr_pkg::MODE_RST}}) && (pair_off_q == 4'h0);
  endproperty
  a_reset_modes: assert property (p_reset_modes) else $error("pairs not LVDS enabled after reset");

  property p_reset_ratios;
    @(posedge I_CLK)
    I_SYS_RST |=> (ratio_a_q == 9'h000) && (ratio_b_q == 9'h000) && !term_q;
  endproperty
  a_reset_ratios: assert property (p_reset_ratios) else $error("dividers not bypassed after reset");

  sequence s_write_ratio_b_hi;
    I_REG_WR && (I_REG_ADDR == bbodr_pkg::ADDR_RATIO_HI);
  endsequence

  property p_ratio_hi;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    s_write_ratio_b_hi |=> (ratio_b_q[8] == $past(I_REG_WDATA[1])) && (ratio_a_q[8] == $past(I_REG_WDATA[0]));
  endproperty
  a_ratio_hi: assert property (p_ratio_hi) else $error("ninth ratio bits misplaced");

  sequence s_write_ratio_b_lo;
    I_REG_WR && (I_REG_ADDR == bbodr_pkg::ADDR_RATIO_B_LO);
  endsequence

  sequence s_read_back_b_lo;
    !I_REG_WR && I_REG_RD && (I_REG_ADDR == bbodr_pkg::ADDR_RATIO_B_LO);
  endsequence

  property p_ratio_b_readback;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    s_write_ratio_b_lo ##1 !I_REG_WR ##1 s_read_back_b_lo |=> (O_REG_RDATA == $past(I_REG_WDATA, 3));
  endproperty
  a_ratio_b_readback: assert property (p_ratio_b_readback) else $error("ratio byte readback wrong");

  property p_rsvd_read;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (I_REG_RD && (I_REG_ADDR == bbodr_pkg::ADDR_RSVD_F)) |=> (O_REG_RDATA == 8'h00);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved register reads nonzero");

  property p_div_release;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (I_DIV_SYNC ##1 !I_DIV_SYNC) |-> (!bank_a_clk && !bank_b_clk);
  endproperty
  a_div_release: assert property (p_div_release) else $error("divider outputs not halted at sync release");

  property p_mode_32_write;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (I_REG_WR && (I_REG_ADDR == bbodr_pkg::ADDR_MODE_32)) |=>
      (mode_q[3] == $past(I_REG_WDATA[bbodr_pkg::MODE_HI_LSB +: bbodr_pkg::MODE_W])) &&
      (mode_q[2] == $past(I_REG_WDATA[bbodr_pkg::MODE_LO_LSB +: bbodr_pkg::MODE_W]));
  endproperty
  a_mode_32_write: assert property (p_mode_32_write) else $error("upper pair driver types misplaced");

  property p_mode_10_write;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (I_REG_WR && (I_REG_ADDR == bbodr_pkg::ADDR_MODE_10)) |=>
      (mode_q[1] == $past(I_REG_WDATA[bbodr_pkg::MODE_HI_LSB +: bbodr_pkg::MODE_W])) &&
      (mode_q[0] == $past(I_REG_WDATA[bbodr_pkg::MODE_LO_LSB +: bbodr_pkg::MODE_W]));
  endproperty
  a_mode_10_write: assert property (p_mode_10_write) else $error("lower pair driver types misplaced");

  property p_off_write;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (I_REG_WR && (I_REG_ADDR == bbodr_pkg::ADDR_PAIR_OFF)) |=>
      (pair_off_q == $past(I_REG_WDATA[bbodr_pkg::PAIR_OFF_LSB +: bbodr_pkg::NUM_PAIRS]));
  endproperty
  a_off_write: assert property (p_off_write) else $error("pair power-down bits misplaced");

  property p_term_write;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (I_REG_WR && (I_REG_ADDR == bbodr_pkg::ADDR_TERM)) |=> (term_q == $past(I_REG_WDATA[bbodr_pkg::TERM_BIT]));
  endproperty
  a_term_write: assert property (p_term_write) else $error("termination bit misplaced");

  property p_ratio_a_lo_write;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (I_REG_WR && (I_REG_ADDR == bbodr_pkg::ADDR_RATIO_A_LO)) |=> (ratio_a_q[7:0] == $past(I_REG_WDATA));
  endproperty
  a_ratio_a_lo_write: assert property (p_ratio_a_lo_write) else $error("bank A ratio low byte lost");

  property p_ratio_b_lo_write;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    s_write_ratio_b_lo |=> (ratio_b_q[7:0] == $past(I_REG_WDATA));
  endproperty
  a_ratio_b_lo_write: assert property (p_ratio_b_lo_write) else $error("bank B ratio low byte lost");

  property p_bank_hiz;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (I_BANK_B_GLITCHLESS_HIZ && !bank_b_clk) |=> (O_BANK_B_PAIR_OE == 4'h0);
  endproperty
  a_bank_hiz: assert property (p_bank_hiz) else $error("bank left driven while forced high-z");

  property p_div_held;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    I_DIV_SYNC |=> (!bank_a_clk && !bank_b_clk);
  endproperty
  a_div_held: assert property (p_div_held) else $error("bank clocks run while dividers held");

  property p_rdata_mode;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (I_REG_RD && !I_REG_WR && (I_REG_ADDR == bbodr_pkg::ADDR_MODE_10)) |=>
      (O_REG_RDATA == {2'h0, $past(mode_q[1]), $past(mode_q[0])});
  endproperty
  a_rdata_mode: assert property (p_rdata_mode) else $error("driver type readback wrong");

endmodule
